/* line_partner.sv */
// remote side model: resolves the serial output wire and the carrier wire
// assumes the bench sets the levels a remote party drives when released
`timescale 1ns/10ps
`default_nettype none
module line_partner (
    // design drive
    input  wire logic so_o,
    input  wire logic so_oe,
    input  wire logic cd_o,
    input  wire logic cd_oe,
    // remote levels
    input  wire logic so_ext,
    input  wire logic cd_ext,
    // resolved wires
    output logic      so_wire,
    output logic      cd_wire
);
    // remote party drives only where the design lets go
    assign so_wire = so_oe ? so_o : so_ext;
    assign cd_wire = cd_oe ? cd_o : cd_ext;
endmodule
`default_nettype wire

/* serial_pin_control_edge_detect.sv */
// serial pin control: output pin modes, loopback routing, control pin edge detection,
// carrier pin functions, all behind an apb slave
// assumes one 100 MHz clock; pins and receiver strobes synchronous to pclk
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "serial_pin_regs.svh"

module serial_pin_control_edge_detect (
    // apb slave
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // serial data pins
    input  wire logic                       serial_in_pin,
    input  wire logic                       serial_out_pin_i,
    output logic                            serial_out_pin_o,
    output logic                            serial_out_pin_oe,
    // carrier detect pin
    input  wire logic                       carrier_detect_pin_i,
    output logic                            carrier_detect_pin_o,
    output logic                            carrier_detect_pin_oe,
    // other control pins
    input  wire serial_pin_pkg::ctrl_pins_t ctrl_pins_i,
    // transmitter and receiver side
    input  wire logic                       tx_data,
    input  wire logic                       receive_bit_clock_rise,
    input  wire logic                       rx_char_busy,
    output logic                            rx_data,
    output serial_pin_pkg::rx_gate_t        rx_gate,
    output logic                            pin_event_pending
);

    localparam int NP = `PIN_COUNT;

    // software registers
    logic [15:0] pin_function_control_reg;
    logic [15:0] channel_command_address_reg;
    logic [15:0] status_irq_control_reg;
    logic [15:0] receive_mode_reg;
    logic [15:0] channel_mode_reg;
    logic        pending_reg;

    // pin tracking state
    logic [NP-1:0] pin_now;
    logic [NP-1:0] sync1_reg;
    logic [NP-1:0] sync2_reg;
    logic [NP-1:0] prev_reg;
    logic [NP-1:0] edge_latch_reg;
    logic [NP-1:0] lu_reg;
    logic [NP-1:0] data_reg;
    logic [NP-1:0] armed_edge;
    logic [NP-1:0] lu_clear;
    logic [15:0]   misc_irq_status;

    // bus strobes
    logic wr_access;
    logic setup;
    logic soft_reset;

    serial_pin_pkg::serial_out_pin_mode_t out_mode;
    serial_pin_pkg::loopback_routing_t    routing;
    serial_pin_pkg::carrier_pin_mode_t    car_mode;

    // address decode, used for both read and write
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `OFS_PIN_FUNCTION_CONTROL) || (a == `OFS_CHANNEL_CMD_ADDRESS)
                 || (a == `OFS_STATUS_IRQ_CONTROL) || (a == `OFS_MISC_IRQ_STATUS)
                 || (a == `OFS_IRQ_CHAIN_CONTROL) || (a == `OFS_RECEIVE_MODE_REG)
                 || (a == `OFS_CHANNEL_MODE_REG);
    endfunction

    // field views
    assign out_mode  = serial_pin_pkg::serial_out_pin_mode_t'(
                           pin_function_control_reg[`SERIAL_OUT_MODE_LSB +: 2]);
    assign car_mode  = serial_pin_pkg::carrier_pin_mode_t'(
                           pin_function_control_reg[`CARRIER_MODE_LSB +: 2]);
    assign routing   = serial_pin_pkg::loopback_routing_t'(
                           channel_command_address_reg[`ROUTING_LSB +: 2]);
    assign setup     = psel & ~penable;
    assign wr_access = psel & penable & pready & pwrite & is_mapped(paddr);
    assign soft_reset = wr_access && (paddr == `OFS_CHANNEL_CMD_ADDRESS)
                      && pwdata[`SOFT_RESET_BIT];
    assign pin_now   = {ctrl_pins_i.rx_clock_pin, ctrl_pins_i.tx_clock_pin,
                        ctrl_pins_i.rx_request_pin, ctrl_pins_i.tx_request_pin,
                        carrier_detect_pin_i, ctrl_pins_i.cts_pin};

    // apb answer: ready and data prepared in the setup cycle, zero wait access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= ~is_mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    `OFS_PIN_FUNCTION_CONTROL: prdata <= {16'h0000, pin_function_control_reg};
                    `OFS_CHANNEL_CMD_ADDRESS:  prdata <= {16'h0000, channel_command_address_reg};
                    `OFS_STATUS_IRQ_CONTROL:   prdata <= {16'h0000, status_irq_control_reg};
                    `OFS_MISC_IRQ_STATUS:      prdata <= {16'h0000, misc_irq_status};
                    `OFS_IRQ_CHAIN_CONTROL:    prdata <= {30'h0, pending_reg, 1'b0};
                    `OFS_RECEIVE_MODE_REG:     prdata <= {16'h0000, receive_mode_reg};
                    `OFS_CHANNEL_MODE_REG:     prdata <= {16'h0000, channel_mode_reg};
                    default:                   prdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // configuration registers; mode fields reset to 00 so the serial output is driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_function_control_reg    <= `RST_REG16;
            channel_command_address_reg <= `RST_REG16;
            status_irq_control_reg      <= `RST_REG16;
            receive_mode_reg            <= `RST_REG16;
            channel_mode_reg            <= `RST_REG16;
        end else if (wr_access) begin
            unique case (paddr)
                `OFS_PIN_FUNCTION_CONTROL: pin_function_control_reg <= pwdata[15:0];
                `OFS_CHANNEL_CMD_ADDRESS:
                    channel_command_address_reg <= {1'b0, pwdata[14:0]};
                `OFS_STATUS_IRQ_CONTROL:   status_irq_control_reg <= pwdata[15:0];
                `OFS_RECEIVE_MODE_REG:     receive_mode_reg <= pwdata[15:0];
                `OFS_CHANNEL_MODE_REG:     channel_mode_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // two-stage synchroniser, then a third stage for edge comparison
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            prev_reg  <= '1;
        end else begin
            sync1_reg <= pin_now;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // per-pin edge latch, latched flag and data bit
    genvar k;
    generate
        for (k = 0; k < NP; k++) begin : g_pin
            assign armed_edge[k] =
                (status_irq_control_reg[`DATA_POS(k)] & sync2_reg[k] & ~prev_reg[k])
              | (status_irq_control_reg[`LATCH_POS(k)] & ~sync2_reg[k] & prev_reg[k]);
            assign lu_clear[k] = wr_access && (paddr == `OFS_MISC_IRQ_STATUS)
                                 && pwdata[`LATCH_POS(k)];
            assign misc_irq_status[`LATCH_POS(k)] = lu_reg[k];
            assign misc_irq_status[`DATA_POS(k)]  = data_reg[k];

            // hidden latch: a new edge wins over the transfer into the flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    edge_latch_reg[k] <= 1'b0;
                end else if (soft_reset) begin
                    edge_latch_reg[k] <= 1'b0;
                end else if (armed_edge[k]) begin
                    edge_latch_reg[k] <= 1'b1;
                end else if (!lu_reg[k] && edge_latch_reg[k]) begin
                    edge_latch_reg[k] <= 1'b0;
                end
            end

            // latched flag: cleared by writing 1 or by soft reset, relatched next cycle if latch waits
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lu_reg[k] <= 1'b0;
                end else if (soft_reset) begin
                    lu_reg[k] <= 1'b0;
                end else if (!lu_reg[k] && edge_latch_reg[k]) begin
                    lu_reg[k] <= 1'b1;
                end else if (lu_clear[k]) begin
                    lu_reg[k] <= 1'b0;
                end
            end

            // data bit tracks the inverted pin while open, frozen while latched
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    data_reg[k] <= 1'b0;
                end else if (!lu_reg[k]) begin
                    data_reg[k] <= ~sync2_reg[k];
                end
            end
        end
    endgenerate
    assign misc_irq_status[3:0] = 4'h0;

    // pin event pending: hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= 1'b0;
        end else if (|(~lu_reg & edge_latch_reg)) begin
            pending_reg <= 1'b1;
        end else if (wr_access && (paddr == `OFS_IRQ_CHAIN_CONTROL)) begin
            pending_reg <= pwdata[`PENDING_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_event_pending <= 1'b0;
        end else begin
            pin_event_pending <= pending_reg;
        end
    end

    // serial output pin drive and receiver data source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin_o  <= 1'b1;
            serial_out_pin_oe <= 1'b1;
            rx_data           <= 1'b1;
        end else begin
            if (routing == serial_pin_pkg::ROUTE_ECHO) begin
                serial_out_pin_o  <= serial_in_pin;
                serial_out_pin_oe <= 1'b1;
            end else begin
                unique case (out_mode)
                    serial_pin_pkg::OUT_TX_DATA: serial_out_pin_o <= tx_data;
                    serial_pin_pkg::OUT_FLOAT:   serial_out_pin_o <= 1'b1;
                    serial_pin_pkg::OUT_LOW:     serial_out_pin_o <= 1'b0;
                    serial_pin_pkg::OUT_HIGH:    serial_out_pin_o <= 1'b1;
                endcase
                serial_out_pin_oe <= (out_mode != serial_pin_pkg::OUT_FLOAT);
            end
            unique case (routing)
                serial_pin_pkg::ROUTE_NORMAL:   rx_data <= serial_in_pin;
                serial_pin_pkg::ROUTE_ECHO:     rx_data <= serial_in_pin;
                serial_pin_pkg::ROUTE_PIN_LOOP: rx_data <= serial_out_pin_i;
                serial_pin_pkg::ROUTE_INT_LOOP: rx_data <= tx_data;
            endcase
        end
    end

    // carrier pin drive: undriven except in the two drive modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_detect_pin_o  <= 1'b0;
            carrier_detect_pin_oe <= 1'b0;
        end else begin
            carrier_detect_pin_o  <= (car_mode == serial_pin_pkg::CAR_DRIVE_HIGH);
            carrier_detect_pin_oe <= (car_mode == serial_pin_pkg::CAR_DRIVE_LOW)
                                   || (car_mode == serial_pin_pkg::CAR_DRIVE_HIGH);
        end
    end

    // receiver gating from the carrier pin
    logic carrier_low;
    logic carrier_gated;
    logic sync_gated;
    assign carrier_low   = ~sync2_reg[`CARRIER_PIN_IDX];
    assign carrier_gated = (car_mode == serial_pin_pkg::CAR_CARRIER_IN)
                         && (receive_mode_reg[`RX_ENABLE_LSB +: 2] == `RX_ENABLE_BY_CARRIER);
    assign sync_gated    = (car_mode == serial_pin_pkg::CAR_SYNC_IN)
                         && ((channel_mode_reg[`RX_PROTOCOL_LSB +: 4] == `RX_PROTO_EXT_SYNC)
                          || (channel_mode_reg[`RX_PROTOCOL_LSB +: 4] == `RX_PROTO_ETHERNET));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_gate.assemble_enable <= 1'b0;
            rx_gate.discard         <= 1'b0;
        end else if (carrier_gated) begin
            rx_gate.assemble_enable <= carrier_low;
            rx_gate.discard         <= rx_char_busy & ~carrier_low;
        end else begin
            rx_gate.assemble_enable <= 1'b1;
            rx_gate.discard         <= 1'b0;
        end
    end

    // sync input: start on the receive clock edge seeing low, stop only between characters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_gate.sample_active <= 1'b0;
        end else if (!sync_gated) begin
            rx_gate.sample_active <= 1'b1;
        end else if (receive_bit_clock_rise) begin
            if (carrier_low) begin
                rx_gate.sample_active <= 1'b1;
            end else if (!rx_char_busy) begin
                rx_gate.sample_active <= 1'b0;
            end
        end
    end

    // checks
    property p_out_low;
        @(posedge pclk) disable iff (!presetn)
        (out_mode == serial_pin_pkg::OUT_LOW && routing != serial_pin_pkg::ROUTE_ECHO)
            |=> (serial_out_pin_oe && !serial_out_pin_o);
    endproperty
    a_out_low: assert property (p_out_low) else $error("serial out not driven low");

    property p_echo;
        @(posedge pclk) disable iff (!presetn)
        (routing == serial_pin_pkg::ROUTE_ECHO) |=> (serial_out_pin_o == $past(serial_in_pin));
    endproperty
    a_echo: assert property (p_echo) else $error("echo does not copy input");

    property p_int_loop;
        @(posedge pclk) disable iff (!presetn)
        (routing == serial_pin_pkg::ROUTE_INT_LOOP) |=> (rx_data == $past(tx_data));
    endproperty
    a_int_loop: assert property (p_int_loop) else $error("internal loop data wrong");

    property p_transfer;
        @(posedge pclk) disable iff (!presetn)
        (!lu_reg[`CARRIER_PIN_IDX] && edge_latch_reg[`CARRIER_PIN_IDX] && !soft_reset)
            |=> (lu_reg[`CARRIER_PIN_IDX] && pending_reg);
    endproperty
    a_transfer: assert property (p_transfer) else $error("latch not transferred");

    property p_frozen;
        @(posedge pclk) disable iff (!presetn)
        lu_reg[0] ##1 lu_reg[0] |-> $stable(data_reg[0]);
    endproperty
    a_frozen: assert property (p_frozen) else $error("latched data bit moved");

    property p_zero_write;
        @(posedge pclk) disable iff (!presetn)
        (lu_reg[0] && !lu_clear[0] && !soft_reset) |=> lu_reg[0];
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("flag cleared without 1");

    property p_carrier_undriven;
        @(posedge pclk) disable iff (!presetn)
        (car_mode == serial_pin_pkg::CAR_CARRIER_IN || car_mode == serial_pin_pkg::CAR_SYNC_IN)
            |=> !carrier_detect_pin_oe;
    endproperty
    a_carrier_undriven: assert property (p_carrier_undriven)
        else $error("carrier pin driven in input mode");

    property p_sync_start;
        @(posedge pclk) disable iff (!presetn)
        (sync_gated && receive_bit_clock_rise && carrier_low) |=> rx_gate.sample_active;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync start missed");

    property p_carrier_gate;
        @(posedge pclk) disable iff (!presetn)
        (carrier_gated && !carrier_low) |=> !rx_gate.assemble_enable;
    endproperty
    a_carrier_gate: assert property (p_carrier_gate) else $error("assembly with carrier high");

    c_relatch: cover property (@(posedge pclk) disable iff (!presetn)
        lu_reg[0] ##1 !lu_reg[0] ##1 lu_reg[0]);
    c_pending: cover property (@(posedge pclk) disable iff (!presetn) $rose(pending_reg));
    c_pin_loop: cover property (@(posedge pclk) disable iff (!presetn)
        routing == serial_pin_pkg::ROUTE_PIN_LOOP && !serial_out_pin_oe);

endmodule
`default_nettype wire

/* serial_pin_pkg.sv */
// types of the serial pin control block
// assumes nothing beyond the register header
package serial_pin_pkg;

    typedef enum logic [1:0] {OUT_TX_DATA, OUT_FLOAT, OUT_LOW, OUT_HIGH} serial_out_pin_mode_t;
    typedef enum logic [1:0] {ROUTE_NORMAL, ROUTE_ECHO, ROUTE_PIN_LOOP, ROUTE_INT_LOOP}
        loopback_routing_t;
    typedef enum logic [1:0] {CAR_CARRIER_IN, CAR_SYNC_IN, CAR_DRIVE_LOW, CAR_DRIVE_HIGH}
        carrier_pin_mode_t;

    // control pins other than the carrier pin
    typedef struct packed {
        logic rx_clock_pin;
        logic tx_clock_pin;
        logic rx_request_pin;
        logic tx_request_pin;
        logic cts_pin;
    } ctrl_pins_t;

    // gating handed to the receiver
    typedef struct packed {
        logic assemble_enable;
        logic discard;
        logic sample_active;
    } rx_gate_t;

endpackage

/* serial_pin_regs.svh */
// register offsets, field positions and reset values of the serial pin control block
// assumes a 32-bit apb slave with each 16-bit register in one aligned word
`ifndef SERIAL_PIN_REGS_SVH
`define SERIAL_PIN_REGS_SVH

// byte offsets
`define OFS_PIN_FUNCTION_CONTROL  8'h00
`define OFS_CHANNEL_CMD_ADDRESS   8'h04
`define OFS_STATUS_IRQ_CONTROL    8'h08
`define OFS_MISC_IRQ_STATUS       8'h0c
`define OFS_IRQ_CHAIN_CONTROL     8'h10
`define OFS_RECEIVE_MODE_REG      8'h14
`define OFS_CHANNEL_MODE_REG      8'h18

// field positions
`define SERIAL_OUT_MODE_LSB   6
`define CARRIER_MODE_LSB      12
`define ROUTING_LSB           8
`define SOFT_RESET_BIT        15
`define PENDING_BIT           1
`define RX_ENABLE_LSB         0
`define RX_PROTOCOL_LSB       0

// per pin status and arm bits: pin k latched flag / fall arm at 2k+5, data / rise arm at 2k+4
`define PIN_COUNT             6
`define LATCH_POS(k)          (2*(k)+5)
`define DATA_POS(k)           (2*(k)+4)
`define CARRIER_PIN_IDX       1

// encodings
`define RX_ENABLE_BY_CARRIER  2'h3
`define RX_PROTO_EXT_SYNC     4'h1
`define RX_PROTO_ETHERNET     4'h9

// reset values
`define RST_REG16             16'h0000

`endif

/* tb_serial_pin_control_edge_detect.sv */
// bench for the serial pin control block: pin table, edge latches, carrier gating
// assumes zero wait apb answers and the line partner as remote side
`timescale 1ns/10ps
`default_nettype none
module tb_serial_pin_control_edge_detect;
    typedef struct packed {
        logic [15:0] pfc;
        logic [15:0] cca;
        logic        sin;
        logic        tx;
        logic        ext;
        logic [4:0]  exp;
    } row_t;
    logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]                 paddr;
    logic [31:0]                pwdata, prdata, rd;
    logic                       sin, so_i, so_o, so_oe, cd_i, cd_o, cd_oe, so_ext, cd_ext;
    logic                       tx, rbc, busy, rx, pend;
    serial_pin_pkg::ctrl_pins_t ctrl;
    serial_pin_pkg::rx_gate_t   gate;
    int                         fails, num_checks, cyc;
    row_t                       rows [11];

    serial_pin_control_edge_detect dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(sin), .serial_out_pin_i(so_i),
        .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe), .carrier_detect_pin_i(cd_i),
        .carrier_detect_pin_o(cd_o), .carrier_detect_pin_oe(cd_oe), .ctrl_pins_i(ctrl),
        .tx_data(tx), .receive_bit_clock_rise(rbc), .rx_char_busy(busy), .rx_data(rx),
        .rx_gate(gate), .pin_event_pending(pend));
    line_partner partner_u (.so_o(so_o), .so_oe(so_oe), .cd_o(cd_o), .cd_oe(cd_oe),
        .so_ext(so_ext), .cd_ext(cd_ext), .so_wire(so_i), .cd_wire(cd_i));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; the hang guard ends this wait only if pready never rises
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    // one receive clock rise after the carrier has settled
    task automatic pulse;
        repeat (3) @(posedge pclk);
        rbc <= 1'b1;
        @(posedge pclk);
        rbc <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sin, tx, rbc, busy, so_ext} = '0;
        ctrl = '1;
        cd_ext = 1'b1;
        fails = 0;
        num_checks = 0;
        cyc = 0;
        // pfc, cca, serial in, tx, remote, {so_o, so_oe, cd_o, cd_oe, rx}
        rows = '{'{16'h0000, 16'h0000, 1'b0, 1'b1, 1'b0, 5'b11000},
                 '{16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0, 5'b01001},
                 '{16'h0040, 16'h0000, 1'b0, 1'b1, 1'b0, 5'b10000},
                 '{16'h2080, 16'h0000, 1'b0, 1'b1, 1'b0, 5'b01010},
                 '{16'h30c0, 16'h0000, 1'b0, 1'b0, 1'b0, 5'b11110},
                 '{16'h0000, 16'h0100, 1'b1, 1'b0, 1'b0, 5'b11001},
                 '{16'h0000, 16'h0200, 1'b0, 1'b1, 1'b0, 5'b11001},
                 '{16'h0080, 16'h0200, 1'b1, 1'b1, 1'b0, 5'b01000},
                 '{16'h0040, 16'h0200, 1'b0, 1'b0, 1'b1, 5'b10001},
                 '{16'h00c0, 16'h0300, 1'b1, 1'b0, 1'b0, 5'b11000},
                 '{16'h1000, 16'h0000, 1'b0, 1'b0, 1'b0, 5'b01000}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("so_oe", so_oe, 1);
        chk("cd_oe", cd_oe, 0);
        rdchk("pfc", 8'h00, 0);
        chk("slverr_ok", err, 0);
        rdchk("misc", 8'h0c, 0);
        apb(1'b0, 8'h1c, 0);
        chk("slverr", err, 1);
        // pin modes and routing table
        foreach (rows[i]) begin
            apb(1'b1, 8'h00, rows[i].pfc);
            apb(1'b1, 8'h04, rows[i].cca);
            sin <= rows[i].sin;
            tx <= rows[i].tx;
            so_ext <= rows[i].ext;
            repeat (4) @(posedge pclk);
            chk("pins", {so_o, so_oe, cd_o & cd_oe, cd_oe, rx}, rows[i].exp);
        end
        // falling edges on every pin latch flag and data
        apb(1'b1, 8'h00, 0);
        apb(1'b1, 8'h08, 32'haaa0);
        ctrl <= '0;
        cd_ext <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("pending", pend, 1);
        rdchk("misc", 8'h0c, 32'hfff0);
        rdchk("chain", 8'h10, 32'h2);
        ctrl <= '1;
        cd_ext <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b1, 8'h0c, 0);
        rdchk("frozen", 8'h0c, 32'hfff0);
        apb(1'b1, 8'h0c, 32'hfff0);
        rdchk("cleared", 8'h0c, 0);
        apb(1'b1, 8'h10, 0);
        repeat (3) @(posedge pclk);
        chk("pend_clr", pend, 0);
        apb(1'b1, 8'h10, 32'h2);
        rdchk("pend_set", 8'h10, 32'h2);
        // edges while latched relatch after the clear
        apb(1'b1, 8'h08, 32'hfff0);
        ctrl <= '0;
        cd_ext <= 1'b0;
        repeat (8) @(posedge pclk);
        ctrl <= '1;
        cd_ext <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b1, 8'h0c, 32'haaa0);
        repeat (4) @(posedge pclk);
        rdchk("relatch", 8'h0c, 32'haaa0);
        apb(1'b1, 8'h04, 32'h8000);
        repeat (2) @(posedge pclk);
        rdchk("softrst", 8'h0c, 0);
        apb(1'b1, 8'h08, 0);
        cd_ext <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk("live", 8'h0c, 32'h40);
        // carrier gates the receiver
        apb(1'b1, 8'h14, 3);
        busy <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("assemble", gate[2:1], 2'b10);
        cd_ext <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("discard", gate[2:1], 2'b01);
        // sync input for both protocols
        apb(1'b1, 8'h14, 0);
        apb(1'b1, 8'h00, 32'h1000);
        for (int p = 1; p < 10; p += 8) begin
            apb(1'b1, 8'h18, p);
            busy <= 1'b0;
            pulse();
            chk("idle", gate[0], 0);
            cd_ext <= 1'b0;
            pulse();
            chk("start", gate[0], 1);
            busy <= 1'b1;
            cd_ext <= 1'b1;
            pulse();
            chk("finish", gate[0], 1);
            busy <= 1'b0;
            pulse();
            chk("stop", gate[0], 0);
        end
        // hardware reset in mid-run clears latched flags and reopens data bits
        apb(1'b1, 8'h08, 32'haaa0);
        ctrl <= '0;
        cd_ext <= 1'b0;
        repeat (8) @(posedge pclk);
        rdchk("latched", 8'h0c, 32'hfff0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("so_oe_rst", so_oe, 1);
        chk("cd_oe_rst", cd_oe, 0);
        chk("pend_rst", pend, 0);
        repeat (4) @(posedge pclk);
        rdchk("misc_rst", 8'h0c, 32'h5550);
        give_verdict();
    end
endmodule
`default_nettype wire
